/* inc/panel_io_defines.vh */
// Offsets, field positions, reset values and timing figures of the panel process image
`ifndef PANEL_IO_DEFINES_VH
`define PANEL_IO_DEFINES_VH

// Standard input image, byte offsets
`define KEY_STATE_OFS      8'h00
`define DIG_INPUT_OFS      8'h01

// Standard output image, byte offsets
`define LED_RED_OFS        8'h00
`define LED_GREEN_OFS      8'h01
`define LED_BLUE_OFS       8'h02
`define DIG_OUTPUT_OFS     8'h03

// Safety image, offsets relative to the configured base
`define SAFE_STATUS_OFS    8'h00
`define SAFE_PIN_FIRST     8'h01
`define SAFE_PIN_LAST      8'h04
`define SAFE_POUT_LAST     8'h03

// Status byte fields
`define ST_ESTOP_BIT       0
`define ST_CONTACT0_BIT    4
`define ST_CONTACT1_BIT    5

// Evaluation modes of the safety slot
`define MODE_NONE          2'b00
`define MODE_SINGLE        2'b01
`define MODE_DUAL          2'b10

// Reset values
`define PLANE_RESET        8'h00
`define DO_RESET           8'h00
`define PROTO_RESET        32'h0000_0000

// Timing
`define CLK_PERIOD_NS      4
`define DIAG_INTERVAL_US   15000
`define TEST_WINDOW_NS     1000
// Edges after the feeds return before the live status byte is trusted again
`define RECOVER_CYC        3'd5

`endif

/* src/panel_io_process_image.v */
// Process image of the key panel: keys, digital IO, tri-colour LEDs and safety status byte
`default_nettype none
`include "panel_io_defines.vh"

// Operation
// - Standard image and safety image are kept separately and independently.
// - Input byte 0 carries keys 0-7, byte 1 digital inputs 0-7, bit n.
// - Output bytes 0-2 are red, green, blue planes; byte 3 drives outputs.
// - Colour decode per LED; patterns 000, 101, 011 switch the LED off.
// - Inputs reserved for safety channels are not reported in standard image.
// - Safety image is five input, four output bytes from a configured base.
// - First safety input byte carries sensor or emergency-stop switch state.
// - Other safety bytes carry protocol elements, not user data.
// - Status bits unused by the selected mode read zero, except bit 0, which is held briefly when dual mode is left during status recovery.
// - Unconfigured safety slot performs no sensor evaluation.
// - Single-channel mode reports contacts in status bits 4 and 5.
// - Dual-channel mode bit 0 is 0 when pressed or faulty, else 1.
// - Each safety input has its own dedicated sensor feed output.
// - Dual-channel evaluation runs its diagnostic test at fixed interval.
module panel_io_process_image #(
  parameter DIAG_CYC = (`DIAG_INTERVAL_US * 1000) / `CLK_PERIOD_NS,
  parameter TEST_CYC = (`TEST_WINDOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire        clk_i,
  input  wire        nrst_i,
  // Cyclic exchange with the field-bus controller
  input  wire        cycle_i,
  input  wire        img_safe_i,
  input  wire [7:0]  safe_base_i,
  input  wire [7:0]  img_addr_i,
  input  wire        img_wr_i,
  input  wire [7:0]  img_wdata_i,
  output reg  [7:0]  img_rdata_o,
  output reg         img_hit_o,
  // Safety protocol engine
  input  wire [31:0] proto_in_i,
  output reg  [31:0] proto_out_o,
  // Slot configuration
  input  wire [1:0]  eval_mode_i,
  input  wire [7:0]  safe_reserve_i,
  // Pins
  input  wire [7:0]  keys_i,
  input  wire [7:0]  standard_input_bit_i,
  output reg  [7:0]  dio_o,
  output reg  [7:0]  dio_oe_o,
  output reg  [7:0]  led_r_o,
  output reg  [7:0]  led_g_o,
  output reg  [7:0]  led_b_o,
  input  wire        safety_input_zero_i,
  input  wire        safety_input_one_i,
  output wire        sensor_feed_zero_o,
  output wire        sensor_feed_one_o,
  output wire        safe_fault_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Offset of an address inside the safety image, wrapping past 8'hff
  function [7:0] rel_ofs;
    input [7:0] addr;
    input [7:0] base;
    begin
      rel_ofs = addr - base;
    end
  endfunction

  // Colour enable: mixed blue with exactly one of red or green is off
  function [7:0] led_on;
    input [7:0] r;
    input [7:0] g;
    input [7:0] b;
    begin
      led_on = ~(b & (r ^ g));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [7:0]  led_red_plane;
  reg  [7:0]  led_green_plane;
  reg  [7:0]  led_blue_plane;
  reg  [7:0]  digital_output_drive;
  reg  [7:0]  key_state_input;
  reg  [7:0]  digital_input_state;
  reg  [7:0]  safety_sensor_status;
  reg  [31:0] proto_in_q;
  reg  [7:0]  next_rdata;
  reg         next_hit;
  reg  [2:0]  recover;
  reg  [7:0]  status_settled;

  wire [7:0]  keys_s;
  wire [7:0]  dins_s;
  wire [1:0]  fi_s;
  wire [7:0]  status_live;
  wire [7:0]  safe_ofs;
  wire [7:0]  on_mask;

  assign safe_ofs = rel_ofs(img_addr_i, safe_base_i);
  assign on_mask  = led_on(led_red_plane, led_green_plane, led_blue_plane);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Keys and standard inputs arrive asynchronously
  pin_sync3 #(
    .W (8)
  ) u_key_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (keys_i),
    .q_o    (keys_s)
  );

  pin_sync3 #(
    .W (8)
  ) u_din_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (standard_input_bit_i),
    .q_o    (dins_s)
  );

  // Fail-safe inputs have their own synchroniser, kept apart from standard
  pin_sync3 #(
    .W (2)
  ) u_safe_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    ({safety_input_one_i, safety_input_zero_i}),
    .q_o    (fi_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Safety evaluation

  safety_eval #(
    .DIAG_CYC (DIAG_CYC),
    .TEST_CYC (TEST_CYC),
    .CW       (22)
  ) u_eval (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .mode_i   (eval_mode_i),
    .fi0_i    (fi_s[0]),
    .fi1_i    (fi_s[1]),
    .feed0_o  (sensor_feed_zero_o),
    .feed1_o  (sensor_feed_one_o),
    .err_o    (safe_fault_o),
    .status_o (status_live)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status recovery after a diagnostic test

  // Feeds return one edge after the window and the synchroniser adds four
  // more, so the live status reads pressed for a few cycles after each test
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      recover <= 3'd0;
    else if (eval_mode_i == `MODE_DUAL && !(sensor_feed_zero_o && sensor_feed_one_o))
      recover <= `RECOVER_CYC;
    else if (recover != 3'd0)
      recover <= recover - 3'd1;
  end

  // Last settled status byte; a real press shows a few cycles later, or a few cycles after the test window ends if pressed in it,
  // far inside the response time the safety controller allows
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      status_settled <= 8'h00;
    else if (recover == 3'd0)
      status_settled <= status_live;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input image snapshot on each cyclic exchange

  // Snapshot keeps all bytes of one exchange coherent
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      key_state_input      <= 8'h00;
      digital_input_state  <= 8'h00;
      safety_sensor_status <= 8'h00;
      proto_in_q           <= `PROTO_RESET;
    end
    else if (cycle_i)
    begin
      key_state_input      <= keys_s;
      // Reserved inputs read zero so safety signals never leak here
      digital_input_state  <= dins_s & ~safe_reserve_i;
      safety_sensor_status <= status_settled;
      proto_in_q           <= proto_in_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output image writes, applied as they arrive

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      led_red_plane        <= `PLANE_RESET;
      led_green_plane      <= `PLANE_RESET;
      led_blue_plane       <= `PLANE_RESET;
      digital_output_drive <= `DO_RESET;
      proto_out_o          <= `PROTO_RESET;
    end
    else if (img_wr_i)
    begin
      if (!img_safe_i)
      begin
        case (img_addr_i)
          `LED_RED_OFS:    led_red_plane        <= img_wdata_i;
          `LED_GREEN_OFS:  led_green_plane      <= img_wdata_i;
          `LED_BLUE_OFS:   led_blue_plane       <= img_wdata_i;
          `DIG_OUTPUT_OFS: digital_output_drive <= img_wdata_i;
          default:         led_red_plane        <= led_red_plane;
        endcase
      end
      else
      begin
        // Protocol bytes pass through untouched; user logic never sees them
        case (safe_ofs)
          8'h00:   proto_out_o[7:0]   <= img_wdata_i;
          8'h01:   proto_out_o[15:8]  <= img_wdata_i;
          8'h02:   proto_out_o[23:16] <= img_wdata_i;
          `SAFE_POUT_LAST:
                   proto_out_o[31:24] <= img_wdata_i;
          default: proto_out_o        <= proto_out_o;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux of the two images

  always @*
  begin
    next_rdata = 8'h00;
    next_hit   = 1'b1;
    if (!img_safe_i)
    begin
      case (img_addr_i)
        `KEY_STATE_OFS: next_rdata = key_state_input;
        `DIG_INPUT_OFS: next_rdata = digital_input_state;
        default:        next_hit   = 1'b0;
      endcase
    end
    else
    begin
      case (safe_ofs)
        `SAFE_STATUS_OFS: next_rdata = safety_sensor_status;
        `SAFE_PIN_FIRST:  next_rdata = proto_in_q[7:0];
        8'h02:            next_rdata = proto_in_q[15:8];
        8'h03:            next_rdata = proto_in_q[23:16];
        `SAFE_PIN_LAST:   next_rdata = proto_in_q[31:24];
        default:          next_hit   = 1'b0;
      endcase
    end
  end

  // Registered read data, one cycle after the address
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      img_rdata_o <= 8'h00;
      img_hit_o   <= 1'b0;
    end
    else
    begin
      img_rdata_o <= next_rdata;
      img_hit_o   <= next_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // LED and digital output drive

  // One register stage after the planes; avoids glitch colours mid-write
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      led_r_o <= 8'h00;
      led_g_o <= 8'h00;
      led_b_o <= 8'h00;
    end
    else
    begin
      led_r_o <= led_red_plane & on_mask;
      led_g_o <= led_green_plane & on_mask;
      led_b_o <= led_blue_plane & on_mask;
    end
  end

  // High-side driver: a pin is driven only while its output bit is set,
  // so a pin left at zero is free to be read as a standard input
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      dio_o    <= 8'h00;
      dio_oe_o <= 8'h00;
    end
    else
    begin
      dio_o    <= digital_output_drive;
      dio_oe_o <= digital_output_drive & ~safe_reserve_i;
    end
  end

endmodule
`default_nettype wire

/* src/pin_sync3.v */
// Three-stage synchroniser with agreement filter for pin inputs
`default_nettype none

module pin_sync3 #(
  parameter W = 8
) (
  input  wire         clk_i,
  input  wire         nrst_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  ////////////////////////////////////////////////////////////////////////////
  // A bit changes only once stages two and three agree; s1 feeds s2 only
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s1  <= {W{1'b0}};
      s2  <= {W{1'b0}};
      s3  <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end
    else
    begin
      s1  <= d_i;
      s2  <= s1;
      s3  <= s2;
      q_o <= (s2 & ~(s2 ^ s3)) | (q_o & (s2 ^ s3));
    end
  end

endmodule
`default_nettype wire

/* src/safety_eval.v */
// Evaluation of the two fail-safe inputs with sensor feeds and periodic diagnostic test
`default_nettype none
`include "panel_io_defines.vh"

module safety_eval #(
  parameter DIAG_CYC = 3750000,
  parameter TEST_CYC = 250,
  parameter CW       = 22
) (
  input  wire       clk_i,
  input  wire       nrst_i,
  input  wire [1:0] mode_i,
  input  wire       fi0_i,
  input  wire       fi1_i,
  output reg        feed0_o,
  output reg        feed1_o,
  output reg        err_o,
  output reg  [7:0] status_o
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_RUN  = 2'b01;
  localparam [1:0] ST_TEST = 2'b10;

  reg [1:0]    state;
  reg [CW-1:0] cnt;
  reg [1:0]    mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interval and test-window sequencing; a mode change restarts the interval
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state  <= ST_IDLE;
      cnt    <= {CW{1'b0}};
      mode_q <= `MODE_NONE;
      err_o  <= 1'b0;
    end
    else
    begin
      mode_q <= mode_i;
      if (mode_i != mode_q || mode_i != `MODE_DUAL)
      begin
        state <= (mode_i == `MODE_NONE) ? ST_IDLE : ST_RUN;
        cnt   <= {CW{1'b0}};
        err_o <= 1'b0;
      end
      else
      begin
        case (state)
          ST_RUN:
          begin
            if (cnt == DIAG_CYC[CW-1:0] - 1'b1)
            begin
              state <= ST_TEST;
              cnt   <= {CW{1'b0}};
            end
            else
              cnt <= cnt + 1'b1;
          end
          ST_TEST:
          begin
            if (cnt == TEST_CYC[CW-1:0] - 1'b1)
            begin
              // Feeds are off: an input still high is a fault (short or stuck)
              err_o <= fi0_i | fi1_i;
              state <= ST_RUN;
              cnt   <= {CW{1'b0}};
            end
            else
              cnt <= cnt + 1'b1;
          end
          default:
          begin
            state <= ST_RUN;
            cnt   <= {CW{1'b0}};
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Each sensor gets its own feed; feeds are off only in the test window and while no mode is set
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      feed0_o <= 1'b0;
      feed1_o <= 1'b0;
    end
    else
    begin
      feed0_o <= (mode_i != `MODE_NONE) && !(state == ST_TEST && mode_i == `MODE_DUAL);
      feed1_o <= (mode_i != `MODE_NONE) && !(state == ST_TEST && mode_i == `MODE_DUAL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status byte; unused bits stay zero, held through the test window
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      status_o <= 8'h00;
    else
    begin
      case (mode_i)
        `MODE_SINGLE:
        begin
          status_o                   <= 8'h00;
          status_o[`ST_CONTACT0_BIT] <= fi0_i;
          status_o[`ST_CONTACT1_BIT] <= fi1_i;
        end
        `MODE_DUAL:
        begin
          if (state != ST_TEST)
          begin
            status_o                <= 8'h00;
            status_o[`ST_ESTOP_BIT] <= fi0_i & fi1_i & ~err_o;
          end
        end
        default:
          status_o <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

/* test/fieldbus_ctrl_model.sv */
// Field-bus controller model: cyclic exchange strobe and image byte transfers
`default_nettype none

module fieldbus_ctrl_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       hit_i,
  output var  logic       cycle_o,
  output var  logic       safe_o,
  output var  logic [7:0] addr_o,
  output var  logic       wr_o,
  output var  logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial
  begin
    cycle_o = 1'b0;
    safe_o  = 1'b0;
    addr_o  = 8'h00;
    wr_o    = 1'b0;
    wdata_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One byte write; data inverted afterwards so stale data never looks valid
  task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    safe_o  <= s;
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask

  // Registered read: answer stands one cycle after the address
  task automatic rd(input logic s, input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge clk_i);
    safe_o <= s;
    addr_o <= a;
    @(posedge clk_i);
    #1;
    d = rdata_i;
    h = hit_i;
  endtask

  // Exchange strobe, one cycle
  task automatic snap();
    @(posedge clk_i);
    cycle_o <= 1'b1;
    @(posedge clk_i);
    cycle_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* test/panel_io_process_image_assertions.sv */
// Concurrent checks on the ports of the panel process image
`default_nettype none
`include "panel_io_defines.vh"

module panel_io_process_image_assertions #(
  parameter int DIAG_CYC = 20,
  parameter int TEST_CYC = 5
) (
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire logic       img_safe_i,
  input wire logic [7:0] safe_base_i,
  input wire logic [7:0] img_addr_i,
  input wire logic       img_wr_i,
  input wire logic [7:0] img_wdata_i,
  input wire logic [7:0] img_rdata_o,
  input wire logic       img_hit_o,
  input wire logic [1:0] eval_mode_i,
  input wire logic [7:0] safe_reserve_i,
  input wire logic [7:0] dio_o,
  input wire logic [7:0] dio_oe_o,
  input wire logic [7:0] led_r_o,
  input wire logic [7:0] led_g_o,
  input wire logic [7:0] led_b_o,
  input wire logic       sensor_feed_zero_o,
  input wire logic       sensor_feed_one_o,
  input wire logic       safe_fault_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Window end may lag the interval by the window itself
  localparam int DIAG_MAX = DIAG_CYC + TEST_CYC;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  ////////////////////////////////////////////////////////////////////////////////
  property p_led_off;
    (led_b_o & (led_r_o ^ led_g_o)) == 8'h00;
  endproperty
  a_led_off: assert property (p_led_off) else $error("led shows an off pattern");

  property p_dout;
    img_wr_i && !img_safe_i && img_addr_i == `DIG_OUTPUT_OFS
      |-> ##2 (dio_o & ~safe_reserve_i) == ($past(img_wdata_i, 2) & ~safe_reserve_i);
  endproperty
  a_dout: assert property (p_dout) else $error("output byte not applied");

  property p_reserved;
    (dio_oe_o & safe_reserve_i) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved pin driven");

  property p_std_miss;
    !img_safe_i && img_addr_i > 8'h01 |=> !img_hit_o && img_rdata_o == 8'h00;
  endproperty
  a_std_miss: assert property (p_std_miss) else $error("unmapped standard read");

  property p_safe_miss;
    img_safe_i && 8'(img_addr_i - safe_base_i) > 8'h04 |=> !img_hit_o && img_rdata_o == 8'h00;
  endproperty
  a_safe_miss: assert property (p_safe_miss) else $error("safety read beyond five bytes");

  property p_status_unused;
    img_safe_i && img_addr_i == safe_base_i |=> (img_rdata_o & 8'hce) == 8'h00;
  endproperty
  a_status_unused: assert property (p_status_unused) else $error("unused status bit set");

  property p_none_feed;
    (eval_mode_i == `MODE_NONE)[*3] |-> !sensor_feed_zero_o && !sensor_feed_one_o && !safe_fault_o;
  endproperty
  a_none_feed: assert property (p_none_feed) else $error("evaluation active with slot unset");

  property p_single_feed;
    (eval_mode_i == `MODE_SINGLE)[*3] |-> sensor_feed_zero_o && sensor_feed_one_o;
  endproperty
  a_single_feed: assert property (p_single_feed) else $error("sensor feed missing");

  property p_test_window;
    eval_mode_i == `MODE_DUAL && $past(eval_mode_i) == `MODE_DUAL && $fell(sensor_feed_zero_o)
      |-> (!sensor_feed_zero_o && !sensor_feed_one_o)[*5];
  endproperty
  a_test_window: assert property (p_test_window) else $error("test window too short");

  property p_test_interval;
    eval_mode_i == `MODE_DUAL && $rose(sensor_feed_zero_o) |-> ##[1:DIAG_MAX] !sensor_feed_zero_o;
  endproperty
  a_test_interval: assert property (p_test_interval) else $error("diagnostic test missed");
endmodule

bind panel_io_process_image panel_io_process_image_assertions #(
  .DIAG_CYC(DIAG_CYC),
  .TEST_CYC(TEST_CYC)
) u_chk (
  .clk_i, .nrst_i, .img_safe_i, .safe_base_i, .img_addr_i, .img_wr_i, .img_wdata_i, .img_rdata_o,
  .img_hit_o, .eval_mode_i, .safe_reserve_i, .dio_o, .dio_oe_o, .led_r_o, .led_g_o, .led_b_o,
  .sensor_feed_zero_o, .sensor_feed_one_o, .safe_fault_o
);
`default_nettype wire

/* test/panel_io_process_image_tb_top.sv */
// Self-checking bench of the panel process image
`default_nettype none
`include "panel_io_defines.vh"

module panel_io_process_image_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [31:0] proto_in_i = 32'h0000_0000;
  logic [1:0]  eval_mode_i = 2'b00;
  logic [7:0]  safe_reserve_i = 8'h00;
  logic [7:0]  safe_base_i = 8'h00;
  logic [7:0]  keys_i = 8'h00;
  logic [7:0]  dio_ext = 8'h00;
  logic [1:0]  contact = 2'b00;
  logic [1:0]  short = 2'b00;
  wire         cycle_i, img_safe_i, img_wr_i, img_hit_o, sensor_feed_zero_o, sensor_feed_one_o, safe_fault_o;
  wire  [7:0]  img_addr_i, img_wdata_i, img_rdata_o, dio_o, dio_oe_o, led_r_o, led_g_o, led_b_o;
  wire  [31:0] proto_out_o;
  // Pin level: driven bit wins, else the external level
  wire  [7:0]  standard_input_bit_i = (dio_oe_o & dio_o) | (~dio_oe_o & dio_ext);
  // Sensors are fed from their own feed; a short bypasses it
  wire         safety_input_zero_i = contact[0] & (sensor_feed_zero_o | short[0]);
  wire         safety_input_one_i = contact[1] & (sensor_feed_one_o | short[1]);
  int          fails = 0;
  int          checked = 0;
  int          cyc = 0;

  // Test window must outlast the feed register plus the synchroniser latency
  panel_io_process_image #(.DIAG_CYC(20), .TEST_CYC(8)) dut (
    .clk_i, .nrst_i, .cycle_i, .img_safe_i, .safe_base_i, .img_addr_i, .img_wr_i, .img_wdata_i,
    .img_rdata_o, .img_hit_o, .proto_in_i, .proto_out_o, .eval_mode_i, .safe_reserve_i, .keys_i,
    .standard_input_bit_i, .dio_o, .dio_oe_o, .led_r_o, .led_g_o, .led_b_o, .safety_input_zero_i,
    .safety_input_one_i, .sensor_feed_zero_o, .sensor_feed_one_o, .safe_fault_o
  );

  fieldbus_ctrl_model ctrl (
    .clk_i, .rdata_i(img_rdata_o), .hit_i(img_hit_o), .cycle_o(cycle_i), .safe_o(img_safe_i),
    .addr_o(img_addr_i), .wr_o(img_wr_i), .wdata_o(img_wdata_i)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial
  forever #2 clk_i = ~clk_i;

  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic rchk(input logic s, input logic [7:0] a, input logic [7:0] ed, input logic eh);
    logic [7:0] d;
    logic       h;
    ctrl.rd(s, a, d, h);
    chk(d, ed);
    chk(h, eh);
  endtask

  task automatic finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_std();
    @(posedge clk_i);
    safe_reserve_i <= 8'h03;
    keys_i <= 8'ha5;
    dio_ext <= 8'hff;
    settle(4);
    ctrl.snap();
    @(posedge clk_i);
    keys_i <= 8'h5a;
    settle(4);
    rchk(1'b0, `KEY_STATE_OFS, 8'ha5, 1'b1);
    rchk(1'b0, `DIG_INPUT_OFS, 8'hfc, 1'b1);
    rchk(1'b0, 8'h02, 8'h00, 1'b0);
    ctrl.snap();
    rchk(1'b0, `KEY_STATE_OFS, 8'h5a, 1'b1);
    $display("test std_inputs done");
  endtask

  task automatic t_out();
    ctrl.wr(1'b0, `DIG_OUTPUT_OFS, 8'h81);
    settle(2);
    chk(dio_oe_o, 8'h80);
    chk(dio_o & 8'hfc, 8'h80);
    ctrl.wr(1'b0, 8'h04, 8'hff);
    settle(2);
    chk(dio_oe_o, 8'h80);
    $display("test outputs done");
  endtask

  // LED n gets colour pattern n, so all eight patterns appear at once
  task automatic t_led();
    ctrl.wr(1'b0, `LED_RED_OFS, 8'hf0);
    ctrl.wr(1'b0, `LED_GREEN_OFS, 8'hcc);
    ctrl.wr(1'b0, `LED_BLUE_OFS, 8'haa);
    settle(2);
    chk(led_r_o, 8'hd0);
    chk(led_g_o, 8'hc4);
    chk(led_b_o, 8'h82);
    $display("test leds done");
  endtask

  // Base near the top so the safety image wraps past address ff
  task automatic t_safe();
    @(posedge clk_i);
    safe_base_i <= 8'hfe;
    proto_in_i <= 32'ha1b2c3d4;
    for (int k = 0; k < 4; k++)
      ctrl.wr(1'b1, 8'hfe + 8'(k), 8'(8'h11 * (k + 1)));
    settle(3);
    chk(proto_out_o, 32'h4433_2211);
    chk(led_r_o, 8'hd0);
    ctrl.snap();
    for (int k = 1; k < 5; k++)
      rchk(1'b1, 8'hfe + 8'(k), 8'(32'ha1b2c3d4 >> (8 * (k - 1))), 1'b1);
    rchk(1'b1, 8'h03, 8'h00, 1'b0);
    rchk(1'b0, `KEY_STATE_OFS, 8'h5a, 1'b1);
    $display("test safety_image done");
  endtask

  task automatic t_single_none();
    @(posedge clk_i);
    eval_mode_i <= `MODE_SINGLE;
    contact <= 2'b01;
    settle(8);
    ctrl.snap();
    rchk(1'b1, 8'hfe, 8'h10, 1'b1);
    @(posedge clk_i);
    contact <= 2'b10;
    settle(8);
    ctrl.snap();
    rchk(1'b1, 8'hfe, 8'h20, 1'b1);
    @(posedge clk_i);
    eval_mode_i <= `MODE_NONE;
    contact <= 2'b11;
    short <= 2'b11;
    settle(8);
    ctrl.snap();
    rchk(1'b1, 8'hfe, 8'h00, 1'b1);
    chk(sensor_feed_zero_o | sensor_feed_one_o, 1'b0);
    $display("test single_none done");
  endtask

  task automatic t_dual();
    @(posedge clk_i);
    eval_mode_i <= `MODE_DUAL;
    short <= 2'b00;
    settle(30);
    ctrl.snap();
    rchk(1'b1, 8'hfe, 8'h01, 1'b1);
    chk(safe_fault_o, 1'b0);
    @(posedge clk_i);
    contact <= 2'b00;
    settle(8);
    ctrl.snap();
    rchk(1'b1, 8'hfe, 8'h00, 1'b1);
    @(posedge clk_i);
    contact <= 2'b11;
    short <= 2'b11;
    settle(45);
    chk(safe_fault_o, 1'b1);
    ctrl.snap();
    rchk(1'b1, 8'hfe, 8'h00, 1'b1);
    @(posedge clk_i);
    short <= 2'b00;
    settle(45);
    chk(safe_fault_o, 1'b0);
    @(posedge clk_i);
    eval_mode_i <= `MODE_NONE;
    $display("test dual done");
  endtask

  initial
  begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_std();
    t_out();
    t_led();
    t_safe();
    t_single_none();
    t_dual();
    finish_test();
  end
endmodule
`default_nettype wire
